// ### rtl/flcs_core.sv
// flash command launch and status flags behind an AHB-Lite register port
`timescale 1ns/100ps
`default_nettype none
module flcs_core
(
    input  wire logic        MCLK,         // bus clock, 40 MHz
    input  wire logic        RST,          // async reset, high
    input  wire logic        HSEL,         // slave select
    input  wire logic [31:0] HADDR,        // address
    input  wire logic [1:0]  HTRANS,       // transfer type
    input  wire logic        HWRITE,       // write
    input  wire logic [2:0]  HSIZE,        // word only
    input  wire logic [31:0] HWDATA,       // write data
    input  wire logic        HREADY,       // bus ready
    output logic      [31:0] HRDATA,       // read data
    output logic             HREADYOUT,    // slave ready
    output logic             HRESP,        // always OKAY
    input  wire logic [7:0]  PROT_RANGE,   // protection range
    input  wire logic [1:0]  SEC_NV,       // stored security code
    input  wire logic        STOP_MODE,    // chip in stop
    input  wire logic        ARR_DONE,     // array operation finished
    input  wire logic        ARR_BLANK_OK, // blank result with done
    output logic             ARR_START,    // start pulse to array
    output logic      [7:0]  ARR_CMD,      // command to array
    output logic      [15:0] ARR_ADDR,     // target address
    output logic      [7:0]  ARR_DATA,     // program data
    output logic      [7:0]  CLK_DIV,      // divider value
    output logic      [1:0]  SEC_STATE     // security state code
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                 wr_stb;
    logic [16:0]          acc_addr;
    logic [31:0]          rdata;
    flcs_pkg::flcs_seq_t  seq_r;
    logic                 cbef_r;
    logic                 ccf_r;
    logic                 pviol_r;
    logic                 accerr_r;
    logic                 blank_r;
    logic                 busy_r;
    logic                 buf_valid_r;
    logic                 div_done_r;
    logic                 stop_q_r;
    logic                 sec_loaded_r;
    logic [7:0]           cmd_r;
    logic [15:0]          taddr_r;
    logic [7:0]           tdata_r;
    logic [7:0]           bcmd_r;
    logic [15:0]          baddr_r;
    logic [7:0]           bdata_r;
    logic [7:0]           run_cmd_r;
    logic                 viol;
    logic                 st_wr;
    logic                 cmd_wr;
    logic                 div_wr;
    logic                 arr_wr;
    logic                 launch_try;
    logic                 arr_err;
    logic                 cmd_err;
    logic                 launch_err;
    logic                 stop_err;
    logic                 launch_ok;
    logic                 pviol_set;
    logic                 hand;
    logic                 run_done;
    logic                 cbef_nxt;
    logic                 busy_nxt;
    logic                 buf_valid_nxt;

    // ------------------------------------------------------------
    // bus front end and protection check
    // ------------------------------------------------------------
    flcs_ahb_front u_front
    (
        .clk      (MCLK),
        .rst      (RST),
        .hsel     (HSEL),
        .haddr    (HADDR[16:0]),
        .htrans   (HTRANS),
        .hwrite   (HWRITE),
        .hready   (HREADY),
        .rdata    (rdata),
        .hrdata_r (HRDATA),
        .hready_r (HREADYOUT),
        .wr_stb   (wr_stb),
        .acc_addr (acc_addr)
    );

    flcs_prot_check u_prot
    (
        .prot_range (PROT_RANGE),
        .addr       (taddr_r),
        .cmd        (cmd_r),
        .violation  (viol)
    );

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            HRESP <= 1'b0;
        else
            HRESP <= 1'b0;
    end

    // ------------------------------------------------------------
    // write decode and sequence checks
    // ------------------------------------------------------------
    assign st_wr    = wr_stb && (acc_addr == flcs_pkg::OFS_STATUS);
    assign cmd_wr   = wr_stb && (acc_addr == flcs_pkg::OFS_COMMAND);
    assign div_wr   = wr_stb && (acc_addr == flcs_pkg::OFS_CLK_DIV);
    assign arr_wr   = wr_stb && acc_addr[flcs_pkg::ARRAY_SEL_BIT];
    // only a one in bit 7 launches; reserved bits never reach any flag
    assign launch_try = st_wr && HWDATA[flcs_pkg::BIT_CBEF];

    assign arr_err  = arr_wr && ((seq_r != flcs_pkg::SEQ_IDLE) || !cbef_r);
    assign cmd_err  = cmd_wr && ((seq_r != flcs_pkg::SEQ_DATA)
                   || !flcs_pkg::cmd_legal(HWDATA[7:0]));
    assign launch_err = launch_try && ((seq_r != flcs_pkg::SEQ_CMD) || !cbef_r
                   || (flcs_pkg::cmd_alters(cmd_r) && !div_done_r)
                   || ((cmd_r != flcs_pkg::CMD_BURST_PROG) && (busy_r || buf_valid_r)));
    assign stop_err  = STOP_MODE && !stop_q_r && busy_r;
    assign pviol_set = launch_try && !launch_err && viol;
    assign launch_ok = launch_try && !launch_err && !viol;
    assign hand      = buf_valid_r && !busy_r;
    assign run_done  = busy_r && ARR_DONE;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            seq_r <= flcs_pkg::SEQ_IDLE;
        else if (arr_err || cmd_err || launch_try)
            seq_r <= flcs_pkg::SEQ_IDLE;
        else if (arr_wr)
            seq_r <= flcs_pkg::SEQ_DATA;
        else if (cmd_wr)
            seq_r <= flcs_pkg::SEQ_CMD;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            taddr_r <= 16'h0000;
            tdata_r <= 8'h00;
            cmd_r   <= 8'h00;
        end
        else
        begin
            if (arr_wr && !arr_err)
            begin
                taddr_r <= acc_addr[15:0];
                tdata_r <= HWDATA[7:0];
            end
            if (cmd_wr && !cmd_err)
                cmd_r <= HWDATA[7:0];
        end
    end

    // ------------------------------------------------------------
    // command buffer and hand-over to the array
    // ------------------------------------------------------------
    always_comb
    begin
        cbef_nxt      = cbef_r;
        buf_valid_nxt = buf_valid_r;
        busy_nxt      = busy_r && !ARR_DONE;
        if (hand)
        begin
            cbef_nxt      = 1'b1;
            buf_valid_nxt = 1'b0;
            busy_nxt      = 1'b1;
        end
        if (launch_ok)
        begin
            cbef_nxt      = 1'b0;
            buf_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cbef_r      <= flcs_pkg::RST_CBEF;
            ccf_r       <= flcs_pkg::RST_CCF;
            busy_r      <= 1'b0;
            buf_valid_r <= 1'b0;
        end
        else
        begin
            cbef_r      <= cbef_nxt;
            busy_r      <= busy_nxt;
            buf_valid_r <= buf_valid_nxt;
            // built from next values so it drops on the same edge as cbef_r, at the end of the launch cycle
            ccf_r       <= cbef_nxt && !busy_nxt && !buf_valid_nxt;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            bcmd_r  <= 8'h00;
            baddr_r <= 16'h0000;
            bdata_r <= 8'h00;
        end
        else if (launch_ok)
        begin
            bcmd_r  <= cmd_r;
            baddr_r <= taddr_r;
            bdata_r <= tdata_r;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ARR_START <= 1'b0;
            ARR_CMD   <= 8'h00;
            ARR_ADDR  <= 16'h0000;
            ARR_DATA  <= 8'h00;
            run_cmd_r <= 8'h00;
        end
        else
        begin
            ARR_START <= hand;
            if (hand)
            begin
                ARR_CMD   <= bcmd_r;
                ARR_ADDR  <= baddr_r;
                ARR_DATA  <= bdata_r;
                run_cmd_r <= bcmd_r;
            end
        end
    end

    // ------------------------------------------------------------
    // error flags: a set in the clearing cycle wins
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            pviol_r <= 1'b0;
        else if (pviol_set)
            pviol_r <= 1'b1;
        else if (st_wr && HWDATA[flcs_pkg::BIT_PVIOL])
            pviol_r <= 1'b0;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            accerr_r <= 1'b0;
        else if (arr_err || cmd_err || launch_err || stop_err)
            accerr_r <= 1'b1;
        else if (st_wr && HWDATA[flcs_pkg::BIT_ACCERR])
            accerr_r <= 1'b0;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            stop_q_r <= 1'b0;
        else
            stop_q_r <= STOP_MODE;
    end

    // ------------------------------------------------------------
    // blank result, security state, divider
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            blank_r <= 1'b0;
        else if (run_done && (run_cmd_r == flcs_pkg::CMD_BLANK_CHECK))
            blank_r <= ARR_BLANK_OK;
        else if (launch_ok)
            blank_r <= 1'b0;
    end

    // stored code is taken one cycle after reset release, never under reset
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sec_loaded_r <= 1'b0;
            SEC_STATE    <= flcs_pkg::SEC_RESET;
        end
        else if (!sec_loaded_r)
        begin
            sec_loaded_r <= 1'b1;
            SEC_STATE    <= SEC_NV;
        end
        else if (run_done && (run_cmd_r == flcs_pkg::CMD_BLANK_CHECK) && ARR_BLANK_OK)
            SEC_STATE <= flcs_pkg::SEC_UNSECURED;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            CLK_DIV    <= flcs_pkg::RST_CLK_DIV;
            div_done_r <= 1'b0;
        end
        else if (div_wr)
        begin
            CLK_DIV    <= HWDATA[7:0];
            div_done_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rdata = 32'h00000000;
        case (acc_addr)
            flcs_pkg::OFS_STATUS:
            begin
                rdata[flcs_pkg::BIT_CBEF]   = cbef_r;
                rdata[flcs_pkg::BIT_CCF]    = ccf_r;
                rdata[flcs_pkg::BIT_PVIOL]  = pviol_r;
                rdata[flcs_pkg::BIT_ACCERR] = accerr_r;
                rdata[flcs_pkg::BIT_BLANK]  = blank_r;
            end
            flcs_pkg::OFS_COMMAND:  rdata[7:0] = cmd_r;
            flcs_pkg::OFS_CLK_DIV:  rdata[7:0] = CLK_DIV;
            flcs_pkg::OFS_PROT:     rdata[7:0] = PROT_RANGE;
            flcs_pkg::OFS_SECURITY: rdata[1:0] = SEC_STATE;
            default:                rdata = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_launch_idle;
        launch_ok && !busy_r && !buf_valid_r;
    endsequence

    sequence s_started;
        ARR_START && (ARR_CMD == $past(cmd_r, 2));
    endsequence

    AST_LAUNCH_STARTS: assert property (@(posedge MCLK) disable iff (RST)
        s_launch_idle |-> ##2 s_started)
        else $error("launched command did not reach the array");

    AST_LAUNCH_CLEARS_CBEF: assert property (@(posedge MCLK) disable iff (RST)
        launch_ok |=> !cbef_r && !ccf_r)
        else $error("launch left buffer-empty or complete set");

    AST_CCF_MATCH: assert property (@(posedge MCLK) disable iff (RST)
        ccf_r == (cbef_r && !busy_r && !buf_valid_r))
        else $error("complete flag disagrees with buffer and busy state");

    AST_NONBURST_WAITS: assert property (@(posedge MCLK) disable iff (RST)
        (buf_valid_r && (bcmd_r != flcs_pkg::CMD_BURST_PROG)) |-> !busy_r)
        else $error("non-burst command buffered behind a running one");

    AST_PVIOL_DISCARD: assert property (@(posedge MCLK) disable iff (RST)
        pviol_set |=> pviol_r && !buf_valid_r ##1 !ARR_START)
        else $error("protected command not discarded");

    AST_PVIOL_HOLD: assert property (@(posedge MCLK) disable iff (RST)
        (pviol_r && !(st_wr && HWDATA[flcs_pkg::BIT_PVIOL])) |=> pviol_r)
        else $error("violation flag cleared without a write of one");

    AST_ILLEGAL_CMD: assert property (@(posedge MCLK) disable iff (RST)
        (cmd_wr && !flcs_pkg::cmd_legal(HWDATA[7:0])) |=> accerr_r && (seq_r == flcs_pkg::SEQ_IDLE))
        else $error("illegal command code not flagged");

    AST_DIV_GUARD: assert property (@(posedge MCLK) disable iff (RST)
        (launch_try && flcs_pkg::cmd_alters(cmd_r) && !div_done_r) |=> accerr_r && !buf_valid_r)
        else $error("program or erase accepted before divider write");

    AST_STOP_ERR: assert property (@(posedge MCLK) disable iff (RST)
        ($rose(STOP_MODE) && busy_r) |=> accerr_r)
        else $error("stop during command did not flag access error");

    AST_BLANK_RESULT: assert property (@(posedge MCLK) disable iff (RST)
        (run_done && (run_cmd_r == flcs_pkg::CMD_BLANK_CHECK)) |=> blank_r == $past(ARR_BLANK_OK))
        else $error("blank flag does not follow blank check result");

    AST_RSVD_ZERO: assert property (@(posedge MCLK) disable iff (RST)
        (!HREADYOUT && !wr_stb && (acc_addr == flcs_pkg::OFS_STATUS)) |=> (HRDATA[3] == 1'b0)
            && (HRDATA[1:0] == 2'b00))
        else $error("reserved status bits read non-zero");

endmodule // flcs_core
`default_nettype wire

// ### rtl/flcs_pkg.sv
// constants, command codes and sequence states of the flash command/status logic
package flcs_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          REG_ADDR_W      = 17;
    localparam logic [16:0] OFS_STATUS      = 17'h00000;
    localparam logic [16:0] OFS_COMMAND     = 17'h00004;
    localparam logic [16:0] OFS_CLK_DIV     = 17'h00008;
    localparam logic [16:0] OFS_PROT        = 17'h0000c;
    localparam logic [16:0] OFS_SECURITY    = 17'h00010;
    localparam int          ARRAY_SEL_BIT   = 16;

    // ------------------------------------------------------------
    // status field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_CBEF        = 7;
    localparam int          BIT_CCF         = 6;
    localparam int          BIT_PVIOL       = 5;
    localparam int          BIT_ACCERR      = 4;
    localparam int          BIT_BLANK       = 2;
    localparam logic        RST_CBEF        = 1'b1;
    localparam logic        RST_CCF         = 1'b1;
    localparam logic [7:0]  RST_CLK_DIV     = 8'h00;
    localparam logic [1:0]  SEC_UNSECURED   = 2'b10;
    localparam logic [1:0]  SEC_RESET       = 2'b11;
    localparam int          PAGE_SHIFT      = 9;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_BLANK_CHECK = 8'h05;
    localparam logic [7:0]  CMD_BYTE_PROG   = 8'h20;
    localparam logic [7:0]  CMD_BURST_PROG  = 8'h25;
    localparam logic [7:0]  CMD_PAGE_ERASE  = 8'h40;
    localparam logic [7:0]  CMD_ARRAY_ERASE = 8'h41;

    typedef enum logic [2:0]
    {
        SEQ_IDLE = 3'b001,
        SEQ_DATA = 3'b010,
        SEQ_CMD  = 3'b100
    } flcs_seq_t;

    function automatic logic cmd_legal(input logic [7:0] c);
        return (c == CMD_BLANK_CHECK) || (c == CMD_BYTE_PROG) || (c == CMD_BURST_PROG)
            || (c == CMD_PAGE_ERASE) || (c == CMD_ARRAY_ERASE);
    endfunction

    // program or erase: needs the divider and the protection check
    function automatic logic cmd_alters(input logic [7:0] c);
        return (c == CMD_BYTE_PROG) || (c == CMD_BURST_PROG)
            || (c == CMD_PAGE_ERASE) || (c == CMD_ARRAY_ERASE);
    endfunction

endpackage

// ### rtl/flcs_ahb_front.sv
// AHB-Lite slave front end: one wait state on every transfer
`timescale 1ns/100ps
`default_nettype none
module flcs_ahb_front
(
    input  wire logic        clk,        // bus clock
    input  wire logic        rst,        // async reset, high
    input  wire logic        hsel,       // slave select
    input  wire logic [16:0] haddr,      // low address bits
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write transfer
    input  wire logic        hready,     // bus ready
    input  wire logic [31:0] rdata,      // read mux of the core
    output logic      [31:0] hrdata_r,   // read data
    output logic             hready_r,   // hreadyout
    output logic             wr_stb,     // write data phase
    output logic      [16:0] acc_addr    // latched address
);
    logic pend_r;
    logic write_r;

    // ------------------------------------------------------------
    // address phase capture, data phase completion
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_r   <= 1'b0;
            write_r  <= 1'b0;
            acc_addr <= 17'h00000;
            hready_r <= 1'b1;
        end
        else if (pend_r)
        begin
            pend_r   <= 1'b0;
            hready_r <= 1'b1;
        end
        else if (hsel && htrans[1] && hready)
        begin
            pend_r   <= 1'b1;
            write_r  <= hwrite;
            acc_addr <= haddr;
            hready_r <= 1'b0;
        end
    end

    // read data registered in the wait cycle, so hrdata comes from a flop
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hrdata_r <= 32'h00000000;
        else if (pend_r && !write_r)
            hrdata_r <= rdata;
    end

    assign wr_stb = pend_r && write_r;

endmodule // flcs_ahb_front
`default_nettype wire

// ### rtl/flcs_prot_check.sv
// protection check of a program or erase target against the protection range
`timescale 1ns/100ps
`default_nettype none
module flcs_prot_check
(
    input  wire logic [7:0]  prot_range, // bit 0 disables, 7:1 select
    input  wire logic [15:0] addr,       // target array address
    input  wire logic [7:0]  cmd,        // command code
    output logic             violation   // target is protected
);
    logic in_block;

    // pages above the selected boundary form the protected block
    assign in_block = !prot_range[0]
                   && (addr[15:flcs_pkg::PAGE_SHIFT] > prot_range[7:1]);

    always_comb
    begin
        case (cmd)
            flcs_pkg::CMD_ARRAY_ERASE: violation = !prot_range[0];
            flcs_pkg::CMD_BYTE_PROG,
            flcs_pkg::CMD_BURST_PROG,
            flcs_pkg::CMD_PAGE_ERASE:  violation = in_block;
            default:                   violation = 1'b0;
        endcase
    end

endmodule // flcs_prot_check
`default_nettype wire

// ### test/flcs_arr_model.sv
// flash array partner: answers each start pulse with a done pulse
`timescale 1ns/100ps
`default_nettype none
module flcs_arr_model
(
    input  wire logic clk,   // bus clock
    input  wire logic rst,   // reset, high
    input  wire logic start, // start pulse
    input  wire logic slow,  // long operations
    input  wire logic blank, // blank result to give
    output logic      done,  // done pulse
    output logic      ok     // blank result
);
    int n;
    // result toggles outside done so a stale value never looks valid
    always @(posedge clk or posedge rst)
    begin
        done <= 1'b0;
        ok   <= ~ok;
        if (rst)
            n <= 0;
        else if (start)
            n <= slow ? 60 : 2 + $urandom % 4;
        else if (n > 0)
        begin
            n <= n - 1;
            if (n == 1)
                {done, ok} <= {1'b1, blank};
        end
    end
endmodule // flcs_arr_model
`default_nettype wire

// ### test/test_flcs_core.sv
// self-checking bench of the flash command and status logic
`timescale 1ns/100ps
`default_nettype none
module test_flcs_core;
    logic        MCLK = 0, RST = 1, HWRITE = 0, STOP_MODE = 0, slow = 0, blank = 0;
    logic        HREADYOUT, HRESP, ARR_START, ARR_DONE, ARR_BLANK_OK;
    logic [1:0]  HTRANS = 0, SEC_STATE;
    logic [7:0]  PROT_RANGE = 8'hff, ARR_CMD, ARR_DATA, CLK_DIV;
    logic [15:0] ARR_ADDR;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, v, rq[$], aq[$];
    logic [7:0]  cl[5] = '{8'h20, 8'h25, 8'h40, 8'h41, 8'h05};
    int          failures = 0, n_tests = 0, cyc = 0;
    event        rd_ev;
    always #12.5 MCLK = ~MCLK;
    flcs_core dut_u (.MCLK, .RST, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .PROT_RANGE, .SEC_NV(2'h3), .STOP_MODE,
        .ARR_DONE, .ARR_BLANK_OK, .ARR_START, .ARR_CMD, .ARR_ADDR, .ARR_DATA, .CLK_DIV, .SEC_STATE);
    flcs_arr_model arr_u (.clk(MCLK), .rst(RST), .start(ARR_START), .slow, .blank, .done(ARR_DONE),
        .ok(ARR_BLANK_OK));
    task automatic cmp(input logic [31:0] g, e);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        {HTRANS, HADDR, HWRITE} <= {2'h2, a, w};
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        {HTRANS, HWDATA} <= {2'h0, d};
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        v = HRDATA;
    endtask
    task automatic rd(input logic [31:0] a, e);
        rq.push_back(e);
        bus(0, a, 0);
        ->rd_ev;
    endtask
    // array write, command write, launch
    task automatic go(input logic [15:0] a, input logic [7:0] d, c, input logic ex);
        if (ex)
            aq.push_back({a, d, c});
        bus(1, {16'h1, a}, {24'h0, d});
        bus(1, 4, {24'h0, c});
        bus(1, 0, 32'h80);
    endtask
    task automatic idle();
        v = 0;
        for (int i = 0; i < 99 && v[6] !== 1'b1; i++)
            bus(0, 0, 0);
    endtask
    always @(rd_ev)
        cmp(v, rq.pop_front());
    always @(posedge MCLK)
        if (ARR_START === 1'b1)
            cmp({ARR_ADDR, ARR_DATA, ARR_CMD}, aq.size() ? aq.pop_front() : 32'hdead);
    always @(posedge MCLK)
        if (++cyc == 8000)
        begin
            failures++;
            test_done();
        end
    initial
    begin
        void'($urandom(32'he2dd));
        repeat (20) @(posedge MCLK);
        RST <= 0;
        @(posedge MCLK);
        rd(0, 32'hc0);
        go(16'h0100, 8'h5a, 8'h20, 0);
        rd(0, 32'hd0);
        bus(1, 0, 32'h4f);
        rd(0, 32'hd0);
        bus(1, 0, 32'h10);
        bus(1, 8, 32'h13);
        rd(8, 32'h13);
        cmp({23'h0, HRESP, CLK_DIV}, 32'h13);
        foreach (cl[i])
        begin
            go(16'($urandom), 8'($urandom), cl[i], 1);
            idle();
            rd(0, 32'hc0);
        end
        go(0, 0, 8'h33, 0);
        rd(0, 32'hd0);
        bus(1, 0, 32'h10);
        bus(1, 4, 32'h20);
        bus(1, 0, 32'h80);
        rd(0, 32'hd0);
        bus(1, 0, 32'h10);
        PROT_RANGE <= 8'h00;
        go(16'hfe00, 8'h11, 8'h20, 0);
        rd(0, 32'he0);
        bus(1, 0, 32'h20);
        rd(0, 32'hc0);
        {PROT_RANGE, blank} <= {8'hff, 1'b1};
        go(0, 0, 8'h05, 1);
        idle();
        rd(0, 32'hc4);
        rd(32'h10, 32'h2);
        cmp({30'h0, SEC_STATE}, 32'h2);
        go(0, 8'h77, 8'h20, 1);
        idle();
        rd(0, 32'hc0);
        slow <= 1;
        go(16'h10, 8'h21, 8'h25, 1);
        go(16'h12, 8'h44, 8'h20, 0);
        rd(0, 32'h90);
        bus(1, 0, 32'h10);
        go(16'h11, 8'h22, 8'h25, 1);
        rd(0, 32'h00);
        idle();
        go(16'h20, 8'h33, 8'h20, 1);
        repeat (4) @(posedge MCLK);
        STOP_MODE <= 1;
        idle();
        rd(0, 32'hd0);
        test_done();
    end
endmodule // test_flcs_core
`default_nettype wire
